// >>> logic/acmp_pkg.sv
/*
 * Constants, types and shared decode for the analog comparator control block.
 * Assumes one 100 MHz system clock and a plain register port with 8-bit data.
 */

package acmp_pkg;

   // Widths and sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CODE_W = 10;
   localparam int NCH = 8;
   localparam int SEL_W = 3;
   localparam int EVT_W = 2;

   typedef logic [ADDR_W-1:0] acmp_addr_t;
   typedef logic [DATA_W-1:0] acmp_data_t;
   typedef logic [CODE_W-1:0] acmp_code_t;
   typedef logic [SEL_W-1:0] acmp_sel_t;

   // Register offsets
   localparam acmp_addr_t OFS_CONV_B = 8'h00;
   localparam acmp_addr_t OFS_CMP_CS = 8'h01;
   localparam acmp_addr_t OFS_EVT_STAT = 8'h02;
   localparam acmp_addr_t OFS_EVT_MASK = 8'h03;

   // Reset values
   localparam acmp_data_t RST_CONV_B = 8'h00;
   localparam acmp_data_t RST_CMP_CS = 8'h00;
   localparam acmp_data_t RST_EVT_MASK = 8'h00;

   // Field positions, converter control b
   localparam int BIT_MUX_EN = 6;
   // Field positions, comparator control and status
   localparam int BIT_PWR_OFF = 7;
   localparam int BIT_POS_BG = 6;
   localparam int BIT_OUT = 5;
   localparam int BIT_FLAG = 4;
   localparam int BIT_IEN = 3;
   localparam int BIT_CAP = 2;
   localparam int BIT_MODE_HI = 1;
   localparam int BIT_MODE_LO = 0;
   // Field positions, event status and mask
   localparam int EVT_RISE = 0;
   localparam int EVT_FALL = 1;

   // Channels with no pin behind them read as the lowest level
   localparam logic [NCH-1:0] CH_UNAVAIL = 8'h0c;

   // Interrupt mode encodings
   typedef enum logic [1:0] {
      ACMP_MODE_TOGGLE = 2'h0,
      ACMP_MODE_RSVD = 2'h1,
      ACMP_MODE_FALL = 2'h2,
      ACMP_MODE_RISE = 2'h3
   } acmp_mode_t;

   // Event selected by the mode field
   function automatic logic acmp_mode_hit(input logic [1:0] mode, input logic rise, input logic fall);
      logic hit;
      hit = 1'b0;
      unique case (acmp_mode_t'(mode))
         ACMP_MODE_TOGGLE: hit = rise | fall;
         ACMP_MODE_RSVD: hit = 1'b0;
         ACMP_MODE_FALL: hit = fall;
         ACMP_MODE_RISE: hit = rise;
      endcase
      return hit;
   endfunction

endpackage

// >>> logic/acmp_edge_if.sv
/*
 * Carrier between the control top and the synchroniser / edge detector.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface acmp_edge_if;
   // Raw comparator result, synchronised result and edge pulses
   logic raw;
   logic out_sync;
   logic rise;
   logic fall;

   modport det (
      input raw,
      output out_sync,
      output rise,
      output fall
   );

   modport ctl (
      output raw,
      input out_sync,
      input rise,
      input fall
   );
endinterface

// >>> logic/acmp_select.sv
/*
 * Input selection and comparison of the comparator, modelled on level codes.
 * Assumes levels are steady codes synchronous to the system clock.
 */
`timescale 1ns/1ps
module acmp_select #(
   parameter int CODE_W = acmp_pkg::CODE_W,
   parameter int NCH = acmp_pkg::NCH
) (
   // Selection controls
   input wire logic pos_bandgap_sel,
   input wire logic neg_mux_enable,
   input wire logic converter_enable,
   input wire acmp_pkg::acmp_sel_t channel_select_low,
   input wire logic power_off,
   // Analog levels
   input wire logic [CODE_W-1:0] pin_level,
   input wire logic [CODE_W-1:0] bandgap_level,
   input wire logic [NCH-1:0][CODE_W-1:0] channel_levels,
   // Result
   output logic raw_out
);
   import acmp_pkg::*;

   logic [CODE_W-1:0] pos;
   logic [CODE_W-1:0] neg;

   // Pick both inputs and compare
   always_comb begin
      pos = pos_bandgap_sel ? bandgap_level : pin_level;
      if (!neg_mux_enable || converter_enable) begin
         neg = bandgap_level;
      end else if (CH_UNAVAIL[channel_select_low]) begin
         neg = '0;
      end else begin
         neg = channel_levels[channel_select_low];
      end
      raw_out = !power_off && (pos > neg);
   end
endmodule // acmp_select

// >>> logic/acmp_edge.sv
/*
 * Two-stage synchroniser and edge detector for the comparator result.
 * Assumes the raw result may change at any time relative to the clock.
 */
`timescale 1ns/1ps
module acmp_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Comparator side
   acmp_edge_if.det e
);
   import acmp_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } acmp_edge_state_t;

   acmp_edge_state_t st_q;
   acmp_edge_state_t st_d;

   // Next state: two stages, then the previous value
   always_comb begin
      st_d = st_q;
      st_d.s1 = e.raw;
      st_d.s2 = st_q.s1;
      st_d.prev = st_q.s2;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs and single-cycle edge pulses
   assign e.out_sync = st_q.s2;
   assign e.rise = st_q.s2 && !st_q.prev;
   assign e.fall = !st_q.s2 && st_q.prev;

   sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##2 (e.out_sync == $past(e.raw, 2)))
      else $error("synchronised output not two cycles behind raw");
   edge_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 (e.rise == (e.out_sync && !$past(e.out_sync))))
      else $error("rise pulse does not match output change");
   edge_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      (e.rise |=> !e.rise) and (e.fall |=> !e.fall) and !(e.rise && e.fall))
      else $error("edge pulse longer than one cycle");
endmodule // acmp_edge

// >>> logic/acmp_ctrl.sv
/*
 * Control top of the analog comparator: registers, input selection,
 * synchronised result, interrupt flag and request, capture routing and
 * an event status / mask pair with one level interrupt.
 * Assumes a single-cycle register port whose strobes are never both high,
 * and converter and CPU signals synchronous to the system clock.
 */
`timescale 1ns/1ps
module acmp_ctrl #(
   parameter int CODE_W = acmp_pkg::CODE_W,
   parameter int NCH = acmp_pkg::NCH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire acmp_pkg::acmp_addr_t reg_addr,
   input wire acmp_pkg::acmp_data_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output acmp_pkg::acmp_data_t reg_rdata,
   // Converter and CPU context
   input wire logic converter_enable,
   input wire acmp_pkg::acmp_sel_t channel_select_low,
   input wire logic global_irq_enable,
   input wire logic cmp_vector_taken,
   // Analog levels
   input wire logic [CODE_W-1:0] cmp_positive_pin_level,
   input wire logic [CODE_W-1:0] bandgap_level,
   input wire logic [NCH-1:0][CODE_W-1:0] channel_levels,
   // Outputs
   output logic cmp_irq_req,
   output logic capture_trigger,
   output logic cmp_power_on,
   output logic evt_irq
);
   import acmp_pkg::*;

   typedef struct packed {
      logic mux_en;
      logic pwr_off;
      logic pos_bg;
      logic flag;
      logic ien;
      logic cap;
      logic [1:0] mode;
      logic [EVT_W-1:0] evt_stat;
      logic [EVT_W-1:0] evt_mask;
      acmp_data_t rdata;
      logic irq_req;
      logic cap_out;
      logic pwr_on;
      logic irq;
   } acmp_ctrl_state_t;

   // Reset: register fields from their reset values, event status, read data and outputs zero, comparator powered
   localparam acmp_ctrl_state_t ST_RST = '{
      mux_en: RST_CONV_B[BIT_MUX_EN],
      pwr_off: RST_CMP_CS[BIT_PWR_OFF],
      pos_bg: RST_CMP_CS[BIT_POS_BG],
      flag: RST_CMP_CS[BIT_FLAG],
      ien: RST_CMP_CS[BIT_IEN],
      cap: RST_CMP_CS[BIT_CAP],
      mode: RST_CMP_CS[BIT_MODE_HI:BIT_MODE_LO],
      evt_stat: '0,
      evt_mask: RST_EVT_MASK[EVT_W-1:0],
      rdata: '0,
      irq_req: 1'b0,
      cap_out: 1'b0,
      pwr_on: !RST_CMP_CS[BIT_PWR_OFF],
      irq: 1'b0
   };

   acmp_ctrl_state_t st_q;
   acmp_ctrl_state_t st_d;

   acmp_edge_if e ();

   logic hit;
   logic wr_conv;
   logic wr_cs;
   logic wr_mask;
   logic rd_stat;
   logic flag_clr;
   logic [EVT_W-1:0] evt_set;
   acmp_data_t cs_view;

   // Input selection and comparison
   acmp_select #(
      .CODE_W(CODE_W),
      .NCH(NCH)
   ) u_select (
      .pos_bandgap_sel(st_q.pos_bg),
      .neg_mux_enable(st_q.mux_en),
      .converter_enable(converter_enable),
      .channel_select_low(channel_select_low),
      .power_off(st_q.pwr_off),
      .pin_level(cmp_positive_pin_level),
      .bandgap_level(bandgap_level),
      .channel_levels(channel_levels),
      .raw_out(e.raw)
   );

   // Synchroniser and edge detection
   acmp_edge u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .e(e.det)
   );

   // Address decode
   assign wr_conv = reg_wr && (reg_addr == OFS_CONV_B);
   assign wr_cs = reg_wr && (reg_addr == OFS_CMP_CS);
   assign wr_mask = reg_wr && (reg_addr == OFS_EVT_MASK);
   assign rd_stat = reg_rd && (reg_addr == OFS_EVT_STAT);

   // Events from the synchronised output
   assign hit = acmp_mode_hit(st_q.mode, e.rise, e.fall);
   assign flag_clr = cmp_vector_taken || (wr_cs && reg_wdata[BIT_FLAG]);
   assign evt_set = {e.fall, e.rise};

   // Live view of the comparator control and status register
   always_comb begin
      cs_view = '0;
      cs_view[BIT_PWR_OFF] = st_q.pwr_off;
      cs_view[BIT_POS_BG] = st_q.pos_bg;
      cs_view[BIT_OUT] = e.out_sync;
      cs_view[BIT_FLAG] = st_q.flag;
      cs_view[BIT_IEN] = st_q.ien;
      cs_view[BIT_CAP] = st_q.cap;
      cs_view[BIT_MODE_HI:BIT_MODE_LO] = st_q.mode;
   end

   // Next state
   always_comb begin
      st_d = st_q;
      // Control writes
      if (wr_conv) begin
         st_d.mux_en = reg_wdata[BIT_MUX_EN];
      end
      if (wr_cs) begin
         st_d.pwr_off = reg_wdata[BIT_PWR_OFF];
         st_d.pos_bg = reg_wdata[BIT_POS_BG];
         st_d.ien = reg_wdata[BIT_IEN];
         st_d.cap = reg_wdata[BIT_CAP];
         st_d.mode = reg_wdata[BIT_MODE_HI:BIT_MODE_LO];
      end
      if (wr_mask) begin
         st_d.evt_mask = reg_wdata[EVT_W-1:0];
      end
      // Flag: a new event wins over a clear in the same cycle
      st_d.flag = hit || (st_q.flag && !flag_clr);
      // Event status: read clears, a new event wins
      st_d.evt_stat = evt_set | (rd_stat ? '0 : st_q.evt_stat);
      // Read data stand for one cycle only
      st_d.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CONV_B: st_d.rdata[BIT_MUX_EN] = st_q.mux_en;
            OFS_CMP_CS: st_d.rdata = cs_view;
            OFS_EVT_STAT: st_d.rdata[EVT_W-1:0] = st_q.evt_stat;
            OFS_EVT_MASK: st_d.rdata[EVT_W-1:0] = st_q.evt_mask;
            default: st_d.rdata = '0;
         endcase
      end
      // Registered outputs
      st_d.irq_req = st_d.flag && st_d.ien && global_irq_enable;
      st_d.cap_out = st_d.cap && e.out_sync;
      st_d.pwr_on = !st_d.pwr_off;
      st_d.irq = |(st_d.evt_stat & st_d.evt_mask);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = st_q.rdata;
   assign cmp_irq_req = st_q.irq_req;
   assign capture_trigger = st_q.cap_out;
   assign cmp_power_on = st_q.pwr_on;
   assign evt_irq = st_q.irq;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   irq_request_a: assert property (
      ##1 (cmp_irq_req == (st_q.flag && st_q.ien && $past(global_irq_enable))))
      else $error("interrupt request does not follow flag and enables");
   flag_set_a: assert property (
      hit |=> st_q.flag)
      else $error("flag not set by selected event");
   flag_vector_a: assert property (
      (cmp_vector_taken && !hit) |=> !st_q.flag)
      else $error("flag not cleared by vector");
   flag_w1c_a: assert property (
      (wr_cs && reg_wdata[BIT_FLAG] && !hit) |=> !st_q.flag)
      else $error("flag not cleared by written one");
   flag_hold_a: assert property (
      (!hit && !flag_clr) |=> (st_q.flag == $past(st_q.flag)))
      else $error("flag changed with no cause");
   mode_rise_a: assert property (
      (st_q.mode == ACMP_MODE_RISE && e.fall && !st_q.flag) |=> !st_q.flag)
      else $error("falling edge set flag in rising mode");
   mode_rsvd_a: assert property (
      (st_q.mode == ACMP_MODE_RSVD && !st_q.flag) |=> !st_q.flag)
      else $error("reserved mode set the flag");
   capture_route_a: assert property (
      ##1 (capture_trigger == (st_q.cap && $past(e.out_sync))))
      else $error("capture trigger not routed from output");
   power_off_a: assert property (
      (wr_cs && reg_wdata[BIT_PWR_OFF]) |=> !cmp_power_on ##2 !e.out_sync)
      else $error("power off not applied");
   neg_bandgap_a: assert property (
      (!st_q.pwr_off && st_q.pos_bg && (!st_q.mux_en || converter_enable)) |-> !e.raw)
      else $error("negative input not bandgap");
   read_once_a: assert property (
      !reg_rd |=> (reg_rdata == '0))
      else $error("read data stand outside the answer cycle");

   rise_flag_c: cover property (st_q.mode == ACMP_MODE_RISE && e.rise ##1 st_q.flag);
   vector_c: cover property (cmp_irq_req ##1 cmp_vector_taken);
   capture_c: cover property (st_q.cap ##1 capture_trigger);
   evt_irq_c: cover property (evt_irq ##1 rd_stat);
endmodule // acmp_ctrl

// >>> testbench/acmp_partner.sv
/*
 * Far side of the comparator: analog level sources and the timer capture
 * front end counting capture events.
 * Assumes levels change just after a rising clock edge.
 */
`timescale 1ns/1ps
module acmp_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Timer capture side
   input wire logic capture_trigger,
   input wire logic cap_irq_enable,
   output int cap_irqs,
   // Analog levels
   output logic [acmp_pkg::CODE_W-1:0] pin_level,
   output logic [acmp_pkg::CODE_W-1:0] bandgap_level,
   output logic [acmp_pkg::NCH-1:0][acmp_pkg::CODE_W-1:0] channel_levels
);
   import acmp_pkg::*;
   logic prev_q;
   // Fixed sources; pinless channels sit high to expose a wrong pick
   initial begin
      pin_level = 10'h100;
      bandgap_level = 10'h200;
      for (int i = 0; i < NCH; i++) begin
         channel_levels[i] = (i == 2 || i == 3) ? 10'h3ff : CODE_W'(10'h050 + 10'h060 * i);
      end
   end
   // Capture interrupt only counts with its enable set
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
         cap_irqs <= 0;
      end else begin
         prev_q <= capture_trigger;
         if (capture_trigger && !prev_q && cap_irq_enable) cap_irqs <= cap_irqs + 1;
      end
   end
   // Pin level change on a clock edge
   task automatic set_pin(input logic [CODE_W-1:0] v);
      @(posedge clk);
      pin_level <= v;
   endtask
endmodule // acmp_partner

// >>> testbench/tb.sv
/*
 * Self-checking bench for the comparator control top.
 * Assumes the partner model supplies levels and counts captures.
 */
`timescale 1ns/1ps
module tb;
   import acmp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   acmp_addr_t reg_addr = 8'h00;
   acmp_data_t reg_wdata = 8'h00;
   acmp_data_t rdv;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   acmp_data_t reg_rdata;
   logic conv_en = 1'b0;
   acmp_sel_t sel = 3'h0;
   logic gie = 1'b0;
   logic vec = 1'b0;
   logic cap_ie = 1'b0;
   logic irq, cap, pwr, evt;
   int cap_irqs;
   int num_errors = 0;
   int total_checks = 0;
   logic [CODE_W-1:0] pin, bg;
   logic [NCH-1:0][CODE_W-1:0] chl;
   // Clock
   always #5 clk = ~clk;
   acmp_partner p (.clk(clk), .rst_n(rst_n), .capture_trigger(cap), .cap_irq_enable(cap_ie),
      .cap_irqs(cap_irqs), .pin_level(pin), .bandgap_level(bg), .channel_levels(chl));
   acmp_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .converter_enable(conv_en),
      .channel_select_low(sel), .global_irq_enable(gie), .cmp_vector_taken(vec),
      .cmp_positive_pin_level(pin), .bandgap_level(bg), .channel_levels(chl),
      .cmp_irq_req(irq), .capture_trigger(cap), .cmp_power_on(pwr), .evt_irq(evt));
   // Register port
   task automatic wr_reg(input acmp_addr_t a, input acmp_data_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input acmp_addr_t a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata;
   endtask
   task automatic chk(input acmp_data_t g, input acmp_data_t e);
      total_checks++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
         num_errors++;
      end
   endtask
   task automatic chk_rd(input acmp_addr_t a, input acmp_data_t e);
      rd_reg(a);
      chk(rdv, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic lvl(input logic [CODE_W-1:0] v);
      p.set_pin(v);
      settle(5);
   endtask
   // Reset values and unmapped read
   task automatic t_reset();
      for (int i = 0; i < 5; i++) chk_rd(i[7:0], 8'h00);
      chk({7'h0, pwr}, 8'h01);
      $display("reset test done");
   endtask
   // Every mode on a rise and a fall, enable off
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr_reg(OFS_CMP_CS, 8'h10 | m[7:0]);
         lvl(10'h300);
         chk_rd(OFS_CMP_CS, 8'h20 | m[7:0] | ((m == 0 || m == 3) ? 8'h10 : 8'h00));
         wr_reg(OFS_CMP_CS, 8'h10 | m[7:0]);
         lvl(10'h100);
         chk_rd(OFS_CMP_CS, m[7:0] | ((m == 0 || m == 2) ? 8'h10 : 8'h00));
         chk({7'h0, irq}, 8'h00);
      end
      $display("mode test done");
   endtask
   // Request, vector clear, global gate, write-one clear
   task automatic t_irq();
      wr_reg(OFS_CMP_CS, 8'h1b);
      gie <= 1'b1;
      lvl(10'h300);
      chk({7'h0, irq}, 8'h01);
      vec <= 1'b1;
      @(posedge clk);
      vec <= 1'b0;
      settle(2);
      chk({7'h0, irq}, 8'h00);
      chk_rd(OFS_CMP_CS, 8'h2b);
      lvl(10'h100);
      gie <= 1'b0;
      lvl(10'h300);
      chk({7'h0, irq}, 8'h00);
      gie <= 1'b1;
      settle(2);
      chk({7'h0, irq}, 8'h01);
      wr_reg(OFS_CMP_CS, 8'h03);
      settle(1);
      chk({7'h0, irq}, 8'h00);
      chk_rd(OFS_CMP_CS, 8'h33);
      wr_reg(OFS_CMP_CS, 8'h13);
      chk_rd(OFS_CMP_CS, 8'h23);
      lvl(10'h100);
      $display("irq test done");
   endtask
   // Capture routing on and off
   task automatic t_capture();
      cap_ie <= 1'b1;
      wr_reg(OFS_CMP_CS, 8'h05);
      lvl(10'h300);
      chk({7'h0, cap}, 8'h01);
      lvl(10'h100);
      chk({7'h0, cap}, 8'h00);
      wr_reg(OFS_CMP_CS, 8'h01);
      lvl(10'h300);
      chk({7'h0, cap}, 8'h00);
      chk(cap_irqs[7:0], 8'h01);
      $display("capture test done");
   endtask
   // Negative input sources and positive bandgap select
   task automatic t_mux();
      conv_en <= 1'b0;
      wr_reg(OFS_CONV_B, 8'h40);
      chk_rd(OFS_CONV_B, 8'h40);
      lvl(10'h1a0);
      for (int s = 0; s < 8; s++) begin
         sel <= s[2:0];
         settle(4);
         chk_rd(OFS_CMP_CS, s < 4 ? 8'h21 : 8'h01);
      end
      sel <= 3'h0;
      conv_en <= 1'b1;
      settle(4);
      chk_rd(OFS_CMP_CS, 8'h01);
      conv_en <= 1'b0;
      wr_reg(OFS_CONV_B, 8'h00);
      settle(4);
      chk_rd(OFS_CMP_CS, 8'h01);
      lvl(10'h300);
      wr_reg(OFS_CMP_CS, 8'h41);
      settle(4);
      chk_rd(OFS_CMP_CS, 8'h41);
      wr_reg(OFS_CMP_CS, 8'h01);
      settle(4);
      chk_rd(OFS_CMP_CS, 8'h21);
      $display("mux test done");
   endtask
   // Power off with enable already clear
   task automatic t_power();
      wr_reg(OFS_CMP_CS, 8'h81);
      settle(4);
      chk({7'h0, pwr}, 8'h00);
      chk_rd(OFS_CMP_CS, 8'h81);
      wr_reg(OFS_CMP_CS, 8'h01);
      settle(4);
      chk({7'h0, pwr}, 8'h01);
      chk_rd(OFS_CMP_CS, 8'h21);
      $display("power test done");
   endtask
   // Event status, mask and level interrupt
   task automatic t_events();
      rd_reg(OFS_EVT_STAT);
      wr_reg(OFS_EVT_MASK, 8'h00);
      lvl(10'h100);
      chk({7'h0, evt}, 8'h00);
      wr_reg(OFS_EVT_MASK, 8'h02);
      settle(1);
      chk({7'h0, evt}, 8'h01);
      chk_rd(OFS_EVT_MASK, 8'h02);
      chk_rd(OFS_EVT_STAT, 8'h02);
      settle(1);
      chk({7'h0, evt}, 8'h00);
      lvl(10'h300);
      chk({7'h0, evt}, 8'h00);
      chk_rd(OFS_EVT_STAT, 8'h01);
      chk_rd(OFS_EVT_STAT, 8'h00);
      $display("event test done");
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_irq();
      t_capture();
      t_mux();
      t_power();
      t_events();
      finish_test();
   end
endmodule // tb
